// [bench/testbench.sv]
/*
 * Self-checking bench for the damping filter mode selector.
 * Assumes the selector's register map, clamping and one-cycle read latency.
 */
`include "damp_sel_defs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic we = 1'b0;
	logic re = 1'b0;
	logic [31:0] rdata;
	logic pos = 1'b0;
	logic dof = 1'b0;
	logic vib = 1'b0;
	logic [11:0] vfreq = 12'h000;
	logic [1:0] mode1, mode2;
	logic [11:0] cfreq [0:1];
	logic [11:0] cdepth [0:1];
	logic [11:0] csetup [0:1];
	logic [11:0] dfreq [0:3];
	int mismatches = 0;
	int n_tests = 0;
	int seed = 32'h9BE8A01D;
	int p [5];
	int q [5];
	int ed [4] = '{0, 0, 0, 0};
	logic [31:0] d;
	logic run;
	int f;
	int corner [6][5] = '{'{1000, 200, 750, 300, 3000}, '{1000, 200, 751, 300, 3000},
		'{1000, 200, 49, 300, 100}, '{500, 200, 500, 300, 600},
		'{0, 0, 0, 0, 0}, '{3000, 0, 50, 0, 50}};

	model_damping_filter_select model_damping_filter_select_inst (.sys_clk_in(clk),
		.sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(we),
		.reg_read_in(re), .reg_rdata_out(rdata), .position_mode_in(pos), .two_dof_in(dof),
		.vib_detect_in(vib), .vib_freq_in(vfreq), .set1_mode_out(mode1),
		.set2_mode_out(mode2), .conv_freq_out(cfreq), .conv_depth_out(cdepth),
		.conv_setup_out(csetup), .damp_freq_out(dfreq));

	initial begin
		forever #2 clk = ~clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic int rnd(input int top);
		return ($random(seed) & 32'h7FFFFFFF) % (top + 1);
	endfunction

	function automatic logic [1:0] exp_mode(input int r[5], input logic on);
		if (r[0] == 0 && r[1] == 0 && r[2] == 0 && r[3] == 0 && r[4] == 0)
			return 2'(damp_sel_pkg::set_off);
		if (on && r[2] >= 50 && r[2] < r[0] && r[0] <= 3000 && r[2] <= r[4] &&
			r[4] <= 4 * r[2] && 4 * r[2] <= 3000)
			return 2'(damp_sel_pkg::set_model);
		return 2'(damp_sel_pkg::set_conventional);
	endfunction

	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task wr(input logic [7:0] a, input int v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 d = rdata;
	endtask

	task pulse(input logic [11:0] v);
		@(posedge clk);
		vfreq <= v;
		vib <= 1'b1;
		@(posedge clk);
		vib <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	task load(input logic [7:0] base, input int r[5]);
		for (int i = 0; i < 5; i++)
			wr(base + 8'(4 * i), r[i]);
		repeat (3) @(posedge clk);
		#1;
	endtask

	// conventional outputs carry anti, anti ratio, response
	task check_set(input int k, input int r[5], input logic [1:0] em);
		logic cv;
		cv = (em == 2'(damp_sel_pkg::set_conventional));
		check("set mode", 32'(em), 32'(k ? mode2 : mode1));
		check("conv freq", cv ? r[2] : 0, 32'(cfreq[k]));
		check("conv depth", cv ? r[3] : 0, 32'(cdepth[k]));
		check("conv setup", cv ? r[4] : 0, 32'(csetup[k]));
	endtask

	task wrap_up;
		if (mismatches == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		wrap_up();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(8'h60);
		check("status after reset", 32'h0, d);
		rd(8'hFC);
		check("unmapped read", 32'h0, d);
		@(posedge clk);
		#1;
		check("read data idle", 32'h0, rdata);
		wr(8'h20, 32'h0FA0);
		rd(8'h20);
		check("freq clamp", 32'h0BB8, d);
		wr(8'h24, 32'h05DC);
		rd(8'h24);
		check("ratio clamp", 32'h03E8, d);
		// corners first, then random sets; 2dof toggles at random
		for (int n = 0; n < 46; n++) begin
			if (n < 6) begin
				p = corner[n];
			end else begin
				p[2] = 50 + rnd(699);
				p[0] = p[2] - 50 + rnd(500);
				p[1] = rnd(1000);
				p[3] = rnd(1000);
				p[4] = p[2] - 20 + rnd(3 * p[2] + 100);
				if (p[4] > 3000)
					p[4] = 3000;
			end
			f = (n < 6) ? 0 : rnd(3);
			run = (f != 1 && f != 2);
			pos <= (f != 1);
			dof <= (f != 2);
			load(8'h20, p);
			check_set(0, p, exp_mode(p, run));
		end
		// product of ratios 9 against 8, then just under
		pos <= 1'b1;
		dof <= 1'b1;
		p = '{1000, 500, 500, 500, 1500};
		q = p;
		wr(8'h00, 3'h4);
		load(8'h20, p);
		load(8'h40, q);
		check_set(0, p, 2'(damp_sel_pkg::set_model));
		check_set(1, q, 2'(damp_sel_pkg::set_conventional));
		rd(8'h60);
		check("mode status", 32'h6, d);
		q[4] = 1333;
		load(8'h40, q);
		check_set(1, q, 2'(damp_sel_pkg::set_model));
		// product exactly 8 does not exceed the limit
		p[4] = 1000;
		q[4] = 2000;
		load(8'h20, p);
		load(8'h40, q);
		check_set(0, p, 2'(damp_sel_pkg::set_model));
		check_set(1, q, 2'(damp_sel_pkg::set_model));
		q[4] = 1500;
		wr(8'h00, 3'h0);
		load(8'h40, q);
		check_set(1, q, 2'(damp_sel_pkg::set_model));
		// auto load: 0 disabled, 1..4 name a filter
		for (int a = 0; a < 5; a++) begin
			wr(8'h04, a);
			f = rnd(3000);
			pulse(12'(f));
			if (a > 0)
				ed[a - 1] = f;
			for (int k = 0; k < 4; k++)
				check("damp freq", ed[k], 32'(dfreq[k]));
		end
		// out-of-range select stores off, detected value clamps, upper bits clamp
		wr(8'h04, 7);
		rd(8'h04);
		check("auto select clamp", 32'h0, d);
		pulse(12'h123);
		check("damp freq idle", ed[3], 32'(dfreq[3]));
		wr(8'h04, 4);
		pulse(12'hFFF);
		check("damp freq detect clamp", 32'h0BB8, 32'(dfreq[3]));
		wr(8'h10, 32'h1005);
		rd(8'h10);
		check("damp freq clamp", 32'h0BB8, d);
		check("damp freq out", 32'h0BB8, 32'(dfreq[2]));
		wrap_up();
	end
endmodule

// [logic/damp_sel_defs.svh]
/*
 * Constants for the model-type damping filter selector: register offsets,
 * reset values and frequency/ratio limits.
 * Assumes frequencies are in 0.1 Hz units and ratios in 0.001 units.
 */
// Notes on behaviour
// - auto select disabled writes no frequency
// - auto select copies detected frequency to filter
// - model filter only in position 2dof mode
// - need anti <= resp <= 4*anti <= 300Hz
// - switch 4, product over 8: second conventional
// - fallback uses anti, anti ratio, response
// - all five zero means set off
// - frequencies accept 0 to 3000
// - ratios accept 0 to 1000
`ifndef DAMP_SEL_DEFS_SVH
`define DAMP_SEL_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFF_SWITCH_SELECT 8'h00
`define OFF_AUTO_SELECT 8'h04
`define OFF_DAMP_FREQ_BASE 8'h08
`define OFF_SET1_BASE 8'h20
`define OFF_SET2_BASE 8'h40
`define OFF_MODE_STATUS 8'h60
`define OFF_CONV_BASE 8'h70

// ----------------------------------------
// limits and resets
// ----------------------------------------
`define FREQ_MAX 12'hBB8
`define RATIO_MAX 12'h3E8
`define FREQ_LOW 12'h032
`define FREQ_HIGH 12'hBB8
`define PRODUCT_LIMIT 6'h08
`define SWITCH_BOTH_MODEL 3'h4
`define SWITCH_RESET 3'h0
`define AUTO_RESET 3'h0
`define PARAM_RESET 12'h000

`endif

// [logic/damp_sel_pkg.sv]
/*
 * Types for the damping filter selector.
 * Assumes the defs header is included by the design file.
 */
package damp_sel_pkg;
	typedef enum logic [1:0] {
		set_off,
		set_conventional,
		set_model
	} set_mode_t;
endpackage

// [logic/model_damping_filter_select.sv]
/*
 * Mode selection for two model-type damping filter sets, plus automatic
 * loading of a detected vibration frequency into one of four damping filters.
 * Assumes the register port master holds strobes one cycle, never both,
 * and that vib_detect_in and the control-mode inputs are on sys_clk_in.
 */
`include "damp_sel_defs.svh"

module model_damping_filter_select (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [31:0] reg_rdata_out,
	input wire logic position_mode_in,
	input wire logic two_dof_in,
	input wire logic vib_detect_in,
	input wire logic [11:0] vib_freq_in,
	output logic [1:0] set1_mode_out,
	output logic [1:0] set2_mode_out,
	output logic [11:0] conv_freq_out [0:1],
	output logic [11:0] conv_depth_out [0:1],
	output logic [11:0] conv_setup_out [0:1],
	output logic [11:0] damp_freq_out [0:3]
);
	// ----------------------------------------
	// parameter storage
	// ----------------------------------------
	// index per set: 0 reso, 1 reso ratio, 2 anti, 3 anti ratio, 4 response
	logic [11:0] set_param [0:1][0:4];
	logic [2:0] switch_select;
	logic [2:0] auto_select;
	logic wr_set1;
	logic wr_set2;
	logic [2:0] wr_idx;
	logic [11:0] wr_val;
	logic [11:0] wr_lim;

	assign wr_set1 = reg_write_in && reg_addr_in >= `OFF_SET1_BASE
		&& reg_addr_in < `OFF_SET1_BASE + 8'h14;
	assign wr_set2 = reg_write_in && reg_addr_in >= `OFF_SET2_BASE
		&& reg_addr_in < `OFF_SET2_BASE + 8'h14;
	assign wr_idx = wr_set1 ? 3'((reg_addr_in - `OFF_SET1_BASE) >> 2)
		: 3'((reg_addr_in - `OFF_SET2_BASE) >> 2);
	assign wr_lim = wr_idx[0] ? `RATIO_MAX : `FREQ_MAX;
	assign wr_val = reg_wdata_in[31:12] != 20'h00000 || reg_wdata_in[11:0] > wr_lim
		? wr_lim : reg_wdata_in[11:0];

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			for (int s = 0; s < 2; s++) begin
				for (int p = 0; p < 5; p++) begin
					set_param[s][p] <= `PARAM_RESET;
				end
			end
		end else if (wr_set1) begin
			set_param[0][wr_idx] <= wr_val;
		end else if (wr_set2) begin
			set_param[1][wr_idx] <= wr_val;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			switch_select <= `SWITCH_RESET;
			auto_select <= `AUTO_RESET;
		end else if (reg_write_in && reg_addr_in == `OFF_SWITCH_SELECT) begin
			switch_select <= reg_wdata_in[2:0];
		end else if (reg_write_in && reg_addr_in == `OFF_AUTO_SELECT) begin
			auto_select <= reg_wdata_in[2:0] > 3'h4 ? 3'h0 : reg_wdata_in[2:0];
		end
	end

	// ----------------------------------------
	// damping frequencies with auto load
	// ----------------------------------------
	logic [11:0] damp_freq [0:3];
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gen_damp
			always_ff @(posedge sys_clk_in) begin
				if (sys_rst_in) begin
					damp_freq[g] <= `PARAM_RESET;
				end else if (vib_detect_in && auto_select == 3'(g + 1)) begin
					damp_freq[g] <= vib_freq_in > `FREQ_MAX ? `FREQ_MAX : vib_freq_in;
				end else if (reg_write_in && reg_addr_in == `OFF_DAMP_FREQ_BASE + 8'(4 * g)) begin
					damp_freq[g] <= reg_wdata_in[31:12] != 20'h00000
						|| reg_wdata_in[11:0] > `FREQ_MAX ? `FREQ_MAX : reg_wdata_in[11:0];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// mode evaluation
	// ----------------------------------------
	// combinational, so any parameter change is seen next cycle
	logic all_zero [0:1];
	logic model_ok [0:1];
	logic [26:0] prod_lhs;
	logic [26:0] prod_rhs;
	damp_sel_pkg::set_mode_t next_mode [0:1];
	logic control_ok;

	assign control_ok = position_mode_in && two_dof_in;

	generate
		for (g = 0; g < 2; g++) begin : gen_eval
			logic [13:0] anti4;
			assign anti4 = {set_param[g][2], 2'b00};
			assign all_zero[g] = set_param[g][0] == 12'h000 && set_param[g][1] == 12'h000
				&& set_param[g][2] == 12'h000 && set_param[g][3] == 12'h000
				&& set_param[g][4] == 12'h000;
			assign model_ok[g] = set_param[g][2] >= `FREQ_LOW
				&& set_param[g][2] < set_param[g][0] && set_param[g][0] <= `FREQ_HIGH
				&& set_param[g][2] <= set_param[g][4] && {2'b00, set_param[g][4]} <= anti4
				&& anti4 <= {2'b00, `FREQ_HIGH};
		end
	endgenerate

	// product test: r1*r2 > 8 as resp1*resp2 > 8*anti1*anti2
	// 27 bits: eight times two full-scale frequencies overflows 26
	assign prod_lhs = {15'h0000, set_param[0][4]} * {15'h0000, set_param[1][4]};
	assign prod_rhs = {12'h000, set_param[0][2], 3'b000} * {15'h0000, set_param[1][2]};

	always_comb begin
		for (int s = 0; s < 2; s++) begin
			if (all_zero[s]) begin
				next_mode[s] = damp_sel_pkg::set_off;
			end else if (control_ok && model_ok[s]) begin
				next_mode[s] = damp_sel_pkg::set_model;
			end else begin
				next_mode[s] = damp_sel_pkg::set_conventional;
			end
		end
		if (switch_select == `SWITCH_BOTH_MODEL && next_mode[0] == damp_sel_pkg::set_model
			&& next_mode[1] == damp_sel_pkg::set_model && prod_lhs > prod_rhs) begin
			next_mode[1] = damp_sel_pkg::set_conventional;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			set1_mode_out <= 2'(damp_sel_pkg::set_off);
			set2_mode_out <= 2'(damp_sel_pkg::set_off);
		end else begin
			set1_mode_out <= 2'(next_mode[0]);
			set2_mode_out <= 2'(next_mode[1]);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		for (int s = 0; s < 2; s++) begin
			if (sys_rst_in) begin
				conv_freq_out[s] <= `PARAM_RESET;
				conv_depth_out[s] <= `PARAM_RESET;
				conv_setup_out[s] <= `PARAM_RESET;
			end else if (next_mode[s] == damp_sel_pkg::set_conventional) begin
				conv_freq_out[s] <= set_param[s][2];
				conv_depth_out[s] <= set_param[s][3];
				conv_setup_out[s] <= set_param[s][4];
			end else begin
				conv_freq_out[s] <= `PARAM_RESET;
				conv_depth_out[s] <= `PARAM_RESET;
				conv_setup_out[s] <= `PARAM_RESET;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		for (int i = 0; i < 4; i++) begin
			damp_freq_out[i] <= sys_rst_in ? `PARAM_RESET : damp_freq[i];
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in || !reg_read_in) begin
			reg_rdata_out <= 32'h00000000;
		end else if (reg_addr_in == `OFF_SWITCH_SELECT) begin
			reg_rdata_out <= {29'h0, switch_select};
		end else if (reg_addr_in == `OFF_AUTO_SELECT) begin
			reg_rdata_out <= {29'h0, auto_select};
		end else if (reg_addr_in >= `OFF_DAMP_FREQ_BASE
			&& reg_addr_in < `OFF_DAMP_FREQ_BASE + 8'h10) begin
			reg_rdata_out <= {20'h0, damp_freq[2'((reg_addr_in - `OFF_DAMP_FREQ_BASE) >> 2)]};
		end else if (reg_addr_in >= `OFF_SET1_BASE && reg_addr_in < `OFF_SET1_BASE + 8'h14) begin
			reg_rdata_out <= {20'h0, set_param[0][3'((reg_addr_in - `OFF_SET1_BASE) >> 2)]};
		end else if (reg_addr_in >= `OFF_SET2_BASE && reg_addr_in < `OFF_SET2_BASE + 8'h14) begin
			reg_rdata_out <= {20'h0, set_param[1][3'((reg_addr_in - `OFF_SET2_BASE) >> 2)]};
		end else if (reg_addr_in == `OFF_MODE_STATUS) begin
			reg_rdata_out <= {28'h0, set2_mode_out, set1_mode_out};
		end else begin
			reg_rdata_out <= 32'h00000000;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// no auto write
	property p_auto_off;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		(auto_select == 3'h0 && !reg_write_in) |=> $stable(damp_freq[0])
			&& $stable(damp_freq[1]) && $stable(damp_freq[2]) && $stable(damp_freq[3]);
	endproperty
	a_auto_off: assert property (p_auto_off) else $error("freq changed while auto off");

	sequence s_vib_to_filter2;
		vib_detect_in && auto_select == 3'h2 && vib_freq_in <= `FREQ_MAX;
	endsequence
	sequence s_filter2_loaded;
		damp_freq[1] == $past(vib_freq_in) ##1 damp_freq_out[1] == $past(vib_freq_in, 2);
	endsequence
	property p_auto_load;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		s_vib_to_filter2 |=> s_filter2_loaded;
	endproperty
	a_auto_load: assert property (p_auto_load) else $error("detected frequency not loaded");

	property p_auto_clamp;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		vib_detect_in && auto_select == 3'h4 && vib_freq_in > `FREQ_MAX
			|=> damp_freq[3] == `FREQ_MAX;
	endproperty
	a_auto_clamp: assert property (p_auto_clamp) else $error("detected frequency not clamped");

	property p_model_gate;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		!(position_mode_in && two_dof_in)
			|=> set1_mode_out != 2'(damp_sel_pkg::set_model)
			&& set2_mode_out != 2'(damp_sel_pkg::set_model);
	endproperty
	a_model_gate: assert property (p_model_gate) else $error("model mode without 2dof");

	property p_order;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		!all_zero[0] && set_param[0][2] >= set_param[0][0]
			|=> set1_mode_out == 2'(damp_sel_pkg::set_conventional);
	endproperty
	a_order: assert property (p_order) else $error("bad order not conventional");

	property p_resp;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		!all_zero[1] && set_param[1][4] < set_param[1][2]
			|=> set2_mode_out == 2'(damp_sel_pkg::set_conventional);
	endproperty
	a_resp: assert property (p_resp) else $error("response below anti not conventional");

	property p_product;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		switch_select == `SWITCH_BOTH_MODEL && prod_lhs > prod_rhs
			|=> !(set1_mode_out == 2'(damp_sel_pkg::set_model)
			&& set2_mode_out == 2'(damp_sel_pkg::set_model));
	endproperty
	a_product: assert property (p_product) else $error("both sets model over product");

	property p_fallback;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		set1_mode_out == 2'(damp_sel_pkg::set_conventional)
			|-> conv_setup_out[0] == $past(set_param[0][4])
			&& conv_freq_out[0] == $past(set_param[0][2]);
	endproperty
	a_fallback: assert property (p_fallback) else $error("fallback setup wrong");

	property p_off;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		all_zero[0] [*2] |-> set1_mode_out == 2'(damp_sel_pkg::set_off);
	endproperty
	a_off: assert property (p_off) else $error("all zero set not off");

	property p_freq_range;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		wr_set1 || wr_set2 |=> set_param[0][0] <= `FREQ_MAX && set_param[0][2] <= `FREQ_MAX
			&& set_param[0][4] <= `FREQ_MAX && set_param[1][0] <= `FREQ_MAX
			&& set_param[1][2] <= `FREQ_MAX && set_param[1][4] <= `FREQ_MAX;
	endproperty
	a_freq_range: assert property (p_freq_range) else $error("frequency beyond range");

	property p_ratio_range;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		wr_set1 || wr_set2 |=> set_param[0][1] <= `RATIO_MAX && set_param[0][3] <= `RATIO_MAX
			&& set_param[1][1] <= `RATIO_MAX && set_param[1][3] <= `RATIO_MAX;
	endproperty
	a_ratio_range: assert property (p_ratio_range) else $error("ratio beyond range");
endmodule
